// ===== verilog/cci_top.sv
`timescale 1ns/100ps
`include "cci_defines.svh"
module cci_top
    import cci_pkg::*;
#(
    parameter int FIFO_DEPTH = 16,
    parameter int PRESS_SCANS = 2,
    parameter int RELEASE_SCANS = 2
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic [`CCI_ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic seg_a_i,
    input wire logic seg_b_i,
    input wire logic seg_c_i,
    input wire logic seg_e_i,
    input wire logic seg_f_i,
    input wire logic seg_g_i,
    input wire logic dp_i,
    input wire logic [3:0] digit_select_bits_i,
    output logic [3:0] data_o,
    output logic flag_o,
    output logic [2:0] key_return_o,
    output logic [1:0] iface_ctrl_o,
    output logic entry_ready_o
);
    localparam int ENT_W = 5;
    localparam int CW = $clog2(FIFO_DEPTH) + 1;

    if (PRESS_SCANS < 1 || PRESS_SCANS > 15) begin : g_bad_press
        $error("PRESS_SCANS must lie in 1..15");
    end
    if (RELEASE_SCANS < 1 || RELEASE_SCANS > 15) begin : g_bad_release
        $error("RELEASE_SCANS must lie in 1..15");
    end

    // Segment decode: {valid, flag, bcd}
    function automatic logic [5:0] seg_decode(input logic [4:0] s,
                                              input logic c);
        logic [5:0] r;
        r = 6'h00;
        case (s)
            `CCI_SEG_0: r = {2'b11, `CCI_BCD_ZERO};
            `CCI_SEG_1: r = {2'b10, 4'h1};
            `CCI_SEG_2: r = {2'b10, 4'h2};
            `CCI_SEG_3: r = {2'b10, 4'h3};
            `CCI_SEG_4: r = {2'b10, 4'h4};
            `CCI_SEG_5: r = {2'b10, 4'h5};
            `CCI_SEG_6: begin
                // Six and E share a,b,e,f,g; only c tells them apart
                if (c) begin
                    r = {2'b10, 4'h6};
                end else begin
                    r = {2'b11, `CCI_BCD_ERROR};
                end
            end
            `CCI_SEG_7: r = {2'b10, 4'h7};
            `CCI_SEG_8: r = {2'b10, 4'h8};
            `CCI_SEG_9: r = {2'b10, 4'h9};
            `CCI_SEG_MINUS: r = {2'b11, `CCI_BCD_MINUS};
            default: r = 6'h00;
        endcase
        return r;
    endfunction : seg_decode

    // Key-return line for an entry; none for an undefined code
    function automatic logic [2:0] key_line(input logic func,
                                            input cci_nibble_t code);
        logic [2:0] k;
        k = `CCI_KEY_NONE;
        if (func) begin
            if (code >= `CCI_FN_CLEAR && code <= `CCI_FN_EQUALS) begin
                k = `CCI_KEY_3;
            end
        end else if (code < `CCI_CODE_NINE) begin
            k = `CCI_KEY_1;
        end else if (code <= `CCI_CODE_PCT) begin
            k = `CCI_KEY_2;
        end
        return k;
    endfunction : key_line

    // Digit-select phase in which the entry's key line is driven
    function automatic cci_nibble_t key_phase(input logic func,
                                              input cci_nibble_t code);
        cci_nibble_t p;
        p = code;
        if (func) begin
            p = code - `CCI_FN_CLEAR;
        end else if (code >= `CCI_CODE_NINE) begin
            p = code - `CCI_CODE_NINE;
        end
        return p;
    endfunction : key_phase

    logic [31:0] rdata_q;
    logic [3:0] data_q;
    logic flag_q;
    logic [2:0] key_q;
    logic [1:0] mode_q;
    logic entry_ready_q;
    logic dp_req_q;
    logic ovfl_q;
    cci_state_e state_q;
    logic [ENT_W-1:0] entry_q;
    logic [3:0] scan_q;
    logic hit_q;

    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [ENT_W-1:0] fifo_out_data;
    logic [CW-1:0] fifo_count;
    logic entry_wr;
    logic [5:0] seg_res;
    logic phase_hit;
    logic scan_end;
    logic head_ok;
    logic [1:0] mode_d;

    assign entry_wr = wr_i && (addr_i == `CCI_REG_ENTRY);
    assign fifo_pop = (state_q == CCI_IDLE);

    // Entries wait here until the sequencer is idle and takes the next one
    cci_fifo #(
        .WIDTH(ENT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .in_valid_i(entry_wr),
        .in_ready_o(fifo_in_ready),
        .in_data_i(wdata_i[`CCI_ENT_FUNC:0]),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_out_data),
        .count_o(fifo_count)
    );

    assign seg_res = seg_decode({seg_a_i, seg_b_i, seg_e_i, seg_f_i,
                                 seg_g_i}, seg_c_i);
    assign head_ok = key_line(fifo_out_data[`CCI_ENT_FUNC],
        fifo_out_data[`CCI_ENT_CODE_HI:0]) != `CCI_KEY_NONE;
    assign phase_hit = (digit_select_bits_i == key_phase(
        entry_q[`CCI_ENT_FUNC], entry_q[`CCI_ENT_CODE_HI:0]));
    assign scan_end = hit_q && !phase_hit;

    always_comb begin
        mode_d = dp_req_q ? `CCI_MODE_DPLOC : `CCI_MODE_READ;
        if (state_q != CCI_IDLE) begin
            mode_d = entry_q[`CCI_ENT_FUNC] ? `CCI_MODE_FUNC
                                            : `CCI_MODE_NUM;
        end
    end

    // Control register
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dp_req_q <= 1'b0;
        end else if (wr_i && addr_i == `CCI_REG_CTRL) begin
            dp_req_q <= wdata_i[`CCI_CTRL_DPREQ];
        end
    end

    // Overflow: a refused entry in the clearing cycle still sets it
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ovfl_q <= 1'b0;
        end else if (entry_wr && !fifo_in_ready) begin
            ovfl_q <= 1'b1;
        end else if (wr_i && addr_i == `CCI_REG_STATUS
                     && wdata_i[`CCI_ST_OVFL]) begin
            ovfl_q <= 1'b0;
        end
    end

    // Entry sequencer
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= CCI_IDLE;
            entry_q <= '0;
            scan_q <= 4'h0;
        end else begin
            case (state_q)
                CCI_IDLE: begin
                    scan_q <= 4'h0;
                    if (fifo_out_valid) begin
                        entry_q <= fifo_out_data;
                        // Undefined codes are dropped without a key
                        if (head_ok) begin
                            state_q <= CCI_PRESS;
                        end
                    end
                end
                CCI_PRESS: begin
                    if (scan_end) begin
                        if (scan_q == 4'(PRESS_SCANS - 1)) begin
                            scan_q <= 4'h0;
                            state_q <= CCI_RELEASE;
                        end else begin
                            scan_q <= scan_q + 4'h1;
                        end
                    end
                end
                CCI_RELEASE: begin
                    // Calculator must see the key up before the next one
                    if (scan_end) begin
                        if (scan_q == 4'(RELEASE_SCANS - 1)) begin
                            scan_q <= 4'h0;
                            state_q <= CCI_IDLE;
                        end else begin
                            scan_q <= scan_q + 4'h1;
                        end
                    end
                end
                default: begin
                    state_q <= CCI_IDLE;
                    scan_q <= 4'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hit_q <= 1'b0;
        end else begin
            hit_q <= (state_q != CCI_IDLE) && phase_hit;
        end
    end

    // Key-return lines
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            key_q <= `CCI_KEY_NONE;
        end else if (state_q == CCI_PRESS && phase_hit) begin
            key_q <= key_line(entry_q[`CCI_ENT_FUNC],
                              entry_q[`CCI_ENT_CODE_HI:0]);
        end else begin
            key_q <= `CCI_KEY_NONE;
        end
    end

    // Data and flag outputs, one cycle behind the pins in read and point modes; entry code while an entry is keyed
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            data_q <= 4'h0;
            flag_q <= 1'b0;
        end else begin
            case (mode_d)
                `CCI_MODE_READ: begin
                    data_q <= seg_res[3:0];
                    flag_q <= seg_res[5] & seg_res[4];
                end
                `CCI_MODE_DPLOC: begin
                    data_q <= dp_i ? digit_select_bits_i : 4'h0;
                    flag_q <= dp_i;
                end
                `CCI_MODE_NUM, `CCI_MODE_FUNC: begin
                    data_q <= entry_q[`CCI_ENT_CODE_HI:0];
                    flag_q <= 1'b0;
                end
                default: begin
                    data_q <= 4'h0;
                    flag_q <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_q <= `CCI_MODE_READ;
            entry_ready_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            entry_ready_q <= fifo_in_ready;
        end
    end

    // Read port; data stand only in the cycle after the strobe
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_i) begin
            rdata_q <= 32'h0000_0000;
            case (addr_i)
                `CCI_REG_CTRL: begin
                    rdata_q[`CCI_CTRL_DPREQ] <= dp_req_q;
                end
                `CCI_REG_STATUS: begin
                    rdata_q[`CCI_ST_DATA_HI:0] <= data_q;
                    rdata_q[`CCI_ST_FLAG] <= flag_q;
                    rdata_q[`CCI_ST_KEY_HI:`CCI_ST_KEY_LO] <= key_q;
                    rdata_q[`CCI_ST_DIGIT_HI:`CCI_ST_DIGIT_LO] <=
                        digit_select_bits_i;
                    rdata_q[`CCI_ST_BUSY] <= (state_q != CCI_IDLE);
                    rdata_q[`CCI_ST_FULL] <= !fifo_in_ready;
                    rdata_q[`CCI_ST_EMPTY] <= !fifo_out_valid;
                    rdata_q[`CCI_ST_OVFL] <= ovfl_q;
                end
                `CCI_REG_LEVEL: begin
                    rdata_q[CW-1:0] <= fifo_count;
                end
                default: begin
                    rdata_q <= 32'h0000_0000;
                end
            endcase
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign rdata_o = rdata_q;
    assign data_o = data_q;
    assign flag_o = flag_q;
    assign key_return_o = key_q;
    assign iface_ctrl_o = mode_q;
    assign entry_ready_o = entry_ready_q;

endmodule : cci_top

// ===== verilog/cci_defines.svh
`ifndef CCI_DEFINES_SVH
`define CCI_DEFINES_SVH

// Register bus
`define CCI_ADDR_W 4
`define CCI_REG_CTRL 4'h0
`define CCI_REG_ENTRY 4'h4
`define CCI_REG_STATUS 4'h8
`define CCI_REG_LEVEL 4'hC

// Control register fields
`define CCI_CTRL_DPREQ 0

// Entry register fields
`define CCI_ENT_CODE_HI 3
`define CCI_ENT_FUNC 4

// Status register fields
`define CCI_ST_DATA_HI 3
`define CCI_ST_FLAG 4
`define CCI_ST_KEY_LO 5
`define CCI_ST_KEY_HI 7
`define CCI_ST_DIGIT_LO 8
`define CCI_ST_DIGIT_HI 11
`define CCI_ST_BUSY 12
`define CCI_ST_FULL 13
`define CCI_ST_EMPTY 14
`define CCI_ST_OVFL 15

// Interface control codes
`define CCI_MODE_READ 2'h0
`define CCI_MODE_NUM 2'h1
`define CCI_MODE_FUNC 2'h2
`define CCI_MODE_DPLOC 2'h3

// Special data codes
`define CCI_BCD_ZERO 4'h0
`define CCI_BCD_MINUS 4'hE
`define CCI_BCD_ERROR 4'hF
`define CCI_CODE_NINE 4'h9
`define CCI_CODE_DP 4'hA
`define CCI_CODE_PCT 4'hB

// Function codes
`define CCI_FN_CLEAR 4'h1
`define CCI_FN_CONST 4'h2
`define CCI_FN_SUB 4'h3
`define CCI_FN_ADD 4'h4
`define CCI_MEMORY_RECALL_FN 4'h5
`define CCI_MEMORY_STORE_FN 4'h6
`define CCI_FN_MUL 4'h7
`define CCI_FN_DIV 4'h8
`define CCI_FN_EQUALS 4'h9

// Segment patterns as {a, b, e, f, g}
`define CCI_SEG_0 5'h1E
`define CCI_SEG_1 5'h08
`define CCI_SEG_2 5'h1D
`define CCI_SEG_3 5'h19
`define CCI_SEG_4 5'h0B
`define CCI_SEG_5 5'h13
`define CCI_SEG_6 5'h17
`define CCI_SEG_7 5'h18
`define CCI_SEG_8 5'h1F
`define CCI_SEG_9 5'h1B
`define CCI_SEG_MINUS 5'h01
`define CCI_SEG_ERROR 5'h17

// Key-return lines, one-hot
`define CCI_KEY_NONE 3'h0
`define CCI_KEY_1 3'h1
`define CCI_KEY_2 3'h2
`define CCI_KEY_3 3'h4

`endif

// ===== verilog/cci_pkg.sv
package cci_pkg;

    typedef enum logic [1:0] {
        CCI_IDLE,
        CCI_PRESS,
        CCI_RELEASE
    } cci_state_e;

    typedef logic [3:0] cci_nibble_t;

endpackage : cci_pkg

// ===== verilog/cci_fifo.sv
`timescale 1ns/100ps
module cci_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 16
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("cci_fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;
    logic [AW-1:0] rd_next;
    logic [WIDTH-1:0] out_data_q;

    assign in_ready_o = (count_q != (AW+1)'(DEPTH));
    assign out_valid_o = (count_q != '0);
    assign push = in_valid_i & in_ready_o;
    assign pop = out_ready_i & out_valid_o;
    assign rd_next = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
    assign out_data_o = out_data_q;
    assign count_o = count_q;

    // Storage has no reset; stale words are never shown as valid
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    // Head word is registered; a write to the new head bypasses the array
    always_ff @(posedge clock_i) begin
        if (push && wr_ptr_q == rd_next) begin
            out_data_q <= in_data_i;
        end else begin
            out_data_q <= mem_q[rd_next];
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

endmodule : cci_fifo

// ===== tb/cci_calc_model.sv
`timescale 1ns/100ps
`include "cci_defines.svh"
module cci_calc_model
    import cci_pkg::*;
(
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire cci_nibble_t offset_i,
    input wire cci_nibble_t dp_pos_i,
    output logic [4:0] pat_o,
    output logic seg_c_o,
    output logic dp_o,
    output cci_nibble_t digit_o,
    output cci_nibble_t sym_o
);
    logic [1:0] dwell_q;
    cci_nibble_t digit_q;

    // Four cycles a phase keeps a scan short
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dwell_q <= 2'h0;
            digit_q <= 4'h0;
        end else begin
            dwell_q <= dwell_q + 2'h1;
            if (dwell_q == 2'h3) begin
                digit_q <= (digit_q == 4'h9) ? 4'h0 : digit_q + 4'h1;
            end
        end
    end

    assign digit_o = digit_q;
    assign sym_o = 4'((5'(digit_q) + 5'(offset_i)) % 5'h0D);
    assign dp_o = (digit_q == dp_pos_i);
    // Segment c only tells error from six
    assign seg_c_o = (sym_o <= 4'h9) && (sym_o != 4'h2);

    always_comb begin
        case (sym_o)
            4'h0: pat_o = `CCI_SEG_0;
            4'h1: pat_o = `CCI_SEG_1;
            4'h2: pat_o = `CCI_SEG_2;
            4'h3: pat_o = `CCI_SEG_3;
            4'h4: pat_o = `CCI_SEG_4;
            4'h5: pat_o = `CCI_SEG_5;
            4'h6: pat_o = `CCI_SEG_6;
            4'h7: pat_o = `CCI_SEG_7;
            4'h8: pat_o = `CCI_SEG_8;
            4'h9: pat_o = `CCI_SEG_9;
            4'hA: pat_o = `CCI_SEG_MINUS;
            4'hB: pat_o = `CCI_SEG_ERROR;
            default: pat_o = 5'h00;
        endcase
    end
endmodule : cci_calc_model

// ===== tb/cci_top_properties.sv
`timescale 1ns/100ps
`include "cci_defines.svh"
module cci_top_chk (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic seg_a_i,
    input wire logic seg_b_i,
    input wire logic seg_c_i,
    input wire logic seg_e_i,
    input wire logic seg_f_i,
    input wire logic seg_g_i,
    input wire logic dp_i,
    input wire logic [3:0] digit_select_bits_i,
    input wire logic [3:0] data_o,
    input wire logic flag_o,
    input wire logic [2:0] key_return_o,
    input wire logic [1:0] iface_ctrl_o
);
    logic [4:0] pat;
    logic up_q;
    logic rdm;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    assign pat = {seg_a_i, seg_b_i, seg_e_i, seg_f_i, seg_g_i};
    assign rdm = up_q && iface_ctrl_o == 2'h0 && key_return_o == 3'h0;

    // Past pins mean nothing at the first edge after reset
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            up_q <= 1'b0;
        end else begin
            up_q <= 1'b1;
        end
    end

    zero_read_a: assert property (
        rdm && $past(iface_ctrl_o) == 2'h0 && $past(pat) == `CCI_SEG_0
        |-> data_o == 4'h0 && flag_o) else $error("zero digit misread");
    minus_code_a: assert property (
        rdm && $past(iface_ctrl_o) == 2'h0 && $past(pat) == `CCI_SEG_MINUS
        |-> data_o == 4'hE && flag_o) else $error("minus misread");
    error_code_a: assert property (
        rdm && $past(iface_ctrl_o) == 2'h0 && !$past(seg_c_i)
        && $past(pat) == `CCI_SEG_ERROR
        |-> data_o == 4'hF && flag_o) else $error("error misread");
    blank_quiet_a: assert property (
        rdm && $past(iface_ctrl_o) == 2'h0 && $past(pat) == 5'h00
        && !$past(seg_c_i) |-> {flag_o, data_o} == 5'h00)
        else $error("blank not quiet");
    dp_position_a: assert property (
        up_q && iface_ctrl_o == 2'h3 && $past(iface_ctrl_o) == 2'h3
        && $past(dp_i) |-> flag_o && data_o == $past(digit_select_bits_i))
        else $error("point position wrong");
    k1_phase_a: assert property (
        key_return_o == 3'h1 |-> $past(digit_select_bits_i) == data_o)
        else $error("first key line out of phase");
    k2_phase_a: assert property (
        key_return_o == 3'h2 |-> $past(digit_select_bits_i) == data_o - 4'h9)
        else $error("second key line out of phase");
    k3_phase_a: assert property (
        key_return_o == 3'h4 |-> iface_ctrl_o == 2'h2
        && $past(digit_select_bits_i) == data_o - 4'h1)
        else $error("third key line out of phase");
    echo_key_a: assert property (
        key_return_o != 3'h0 |-> $onehot(key_return_o) && !flag_o
        && iface_ctrl_o inside {2'h1, 2'h2}) else $error("echo not marked");
endmodule : cci_top_chk

bind cci_top cci_top_chk chk_u (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .seg_a_i(seg_a_i),
    .seg_b_i(seg_b_i), .seg_c_i(seg_c_i), .seg_e_i(seg_e_i),
    .seg_f_i(seg_f_i), .seg_g_i(seg_g_i), .dp_i(dp_i),
    .digit_select_bits_i(digit_select_bits_i), .data_o(data_o),
    .flag_o(flag_o), .key_return_o(key_return_o),
    .iface_ctrl_o(iface_ctrl_o)
);

// ===== tb/cci_top_tb_top.sv
`timescale 1ns/100ps
`include "cci_defines.svh"
`define CCI_CHK(nm, ex, got) \
    begin \
        samples_checked++; \
        if ((got) !== (ex)) begin \
            failures++; \
            $display("BAD %s exp %h got %h", nm, ex, got); \
        end \
    end
module cci_top_tb_top;
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [3:0] offset = 4'h0;
    logic [3:0] dp_pos = 4'h0;
    logic [31:0] rdata_o;
    logic [4:0] pat;
    logic seg_c, dp, entry_ready_o, flag_o;
    logic [3:0] ds, sym, data_o;
    logic [2:0] key_return_o;
    logic [1:0] iface_ctrl_o;
    int failures = 0;
    int samples_checked = 0;
    logic [63:0] rd_q[$];
    logic [12:0] key_q[$];
    logic armed, rd_p, dp_p;
    logic [2:0] kr_p;
    logic [3:0] ds_p, sym_p;
    logic [1:0] if_p;

    cci_calc_model calc_u (.clock_i(clock_i), .arst_n_i(arst_n_i),
        .offset_i(offset), .dp_pos_i(dp_pos), .pat_o(pat), .seg_c_o(seg_c),
        .dp_o(dp), .digit_o(ds), .sym_o(sym));
    cci_top #(.PRESS_SCANS(1), .RELEASE_SCANS(1)) dut_u (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .seg_a_i(pat[4]), .seg_b_i(pat[3]), .seg_c_i(seg_c),
        .seg_e_i(pat[2]), .seg_f_i(pat[1]), .seg_g_i(pat[0]), .dp_i(dp),
        .digit_select_bits_i(ds), .data_o(data_o), .flag_o(flag_o),
        .key_return_o(key_return_o), .iface_ctrl_o(iface_ctrl_o),
        .entry_ready_o(entry_ready_o));

    initial begin
        forever #5 clock_i = ~clock_i;
    end

    function automatic logic [4:0] read_exp(input logic [3:0] s);
        if (s == 4'h0) return 5'h10;
        if (s <= 4'h9) return {1'b0, s};
        if (s == 4'hA) return 5'h1E;
        if (s == 4'hB) return 5'h1F;
        return 5'h00;
    endfunction : read_exp

    task automatic print_verdict();
        if (failures == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    task automatic check_cycle();
        logic [63:0] rn;
        logic [12:0] kn;
        logic [6:0] eo;
        eo = {iface_ctrl_o, flag_o, data_o};
        if (rd_p) begin
            rn = rd_q.pop_front();
            `CCI_CHK("rdata", rn[31:0], rdata_o & rn[63:32])
        end
        if (key_return_o != 3'h0 && kr_p == 3'h0) begin
            kn = (key_q.size() == 0) ? 13'h1FFF : key_q.pop_front();
            `CCI_CHK("key", kn[10:4], {key_return_o, ds_p})
            `CCI_CHK("echo", {kn[12:11], 1'b0, kn[3:0]}, eo)
        end
        if (iface_ctrl_o == 2'h0 && if_p == 2'h0 && key_return_o == 3'h0)
            `CCI_CHK("read", read_exp(sym_p), {flag_o, data_o})
        if (iface_ctrl_o == 2'h3 && if_p == 2'h3)
            `CCI_CHK("point", dp_p ? {1'b1, ds_p} : 5'h00, eo[4:0])
    endtask : check_cycle

    always @(posedge clock_i) begin
        if (!arst_n_i) begin
            armed = 1'b0;
        end else begin
            if (armed) check_cycle();
            armed = 1'b1;
            rd_p = rd_i;
            kr_p = key_return_o;
            ds_p = ds;
            sym_p = sym;
            dp_p = dp;
            if_p = iface_ctrl_o;
        end
    end

    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        rd_i <= 1'b0;
        @(posedge clock_i);
    endtask : bus_wr

    task automatic bus_rd(input logic [3:0] a, input logic [31:0] m,
                          input logic [31:0] e);
        addr_i <= a;
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        rd_q.push_back({m, e});
        @(posedge clock_i);
    endtask : bus_rd

    task automatic bus_idle();
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(posedge clock_i);
    endtask : bus_idle

    task automatic entry(input logic f, input logic [3:0] c);
        bus_wr(`CCI_REG_ENTRY, {27'h0, f, c});
        if (!f && c <= 4'h8) begin
            key_q.push_back({2'h1, 3'h1, c, c});
        end else if (!f && c <= 4'hB) begin
            key_q.push_back({2'h1, 3'h2, c - 4'h9, c});
        end else if (f && c != 4'h0 && c <= 4'h9) begin
            key_q.push_back({2'h2, 3'h4, c - 4'h1, c});
        end
    endtask : entry

    // Release needs the phase once more, so ask for a long quiet stretch
    task automatic wait_idle();
        int quiet;
        quiet = 0;
        for (int n = 0; n < 20000 && quiet < 100; n++) begin
            @(posedge clock_i);
            quiet = (key_q.size() == 0 && key_return_o == 3'h0)
                ? quiet + 1 : 0;
        end
        if (quiet < 100) begin
            failures++;
            print_verdict();
        end
    endtask : wait_idle

    initial begin
        logic [3:0] code;
        void'($urandom(58));
        repeat (10) @(posedge clock_i);
        arst_n_i <= 1'b1;
        @(posedge clock_i);
        for (int i = 0; i < 6; i++) begin
            offset <= 4'($urandom % 13);
            repeat (40) @(posedge clock_i);
        end
        bus_wr(`CCI_REG_CTRL, 32'h1);
        bus_rd(`CCI_REG_CTRL, 32'hFFFFFFFF, 32'h1);
        bus_idle();
        for (int i = 0; i < 3; i++) begin
            dp_pos <= 4'($urandom % 10);
            repeat (40) @(posedge clock_i);
        end
        bus_wr(`CCI_REG_CTRL, 32'h0);
        bus_wr(4'h2, 32'hFFFFFFFF);
        bus_rd(4'h2, 32'hFFFFFFFF, 32'h0);
        bus_idle();
        for (int c = 0; c < 13; c++) entry(1'b0, 4'(c));
        bus_idle();
        wait_idle();
        for (int c = 0; c < 11; c++) entry(1'b1, 4'(c));
        bus_idle();
        wait_idle();
        code = 4'($urandom % 12);
        for (int i = 0; i < 20; i++) entry(1'b0, code);
        repeat (3) void'(key_q.pop_back());
        bus_rd(`CCI_REG_LEVEL, 32'hFFFFFFFF, 32'h10);
        bus_rd(`CCI_REG_STATUS, 32'hF000, 32'hB000);
        bus_idle();
        @(negedge clock_i);
        `CCI_CHK("ready", 1'b0, entry_ready_o)
        wait_idle();
        bus_wr(`CCI_REG_STATUS, 32'h8000);
        bus_rd(`CCI_REG_STATUS, 32'hE000, 32'h4000);
        bus_idle();
        bus_idle();
        print_verdict();
    end
endmodule : cci_top_tb_top
